// *** hdl/ced_pkg.sv ***
// shared types and constants for the extension opcode decoder
package ced_pkg;

    // instruction field positions
    localparam int CED_ROW_HI = 31;
    localparam int CED_ROW_LO = 29;
    localparam int CED_COL_HI = 28;
    localparam int CED_COL_LO = 26;
    localparam int CED_FROW_HI = 5;
    localparam int CED_FROW_LO = 3;
    localparam int CED_FCOL_HI = 2;
    localparam int CED_FCOL_LO = 0;
    localparam int CED_SUB_HI = 10;
    localparam int CED_SUB_LO = 6;
    localparam int CED_ROT_BIT = 6;
    localparam int CED_IMM_SEL_HI = 25;
    localparam int CED_IMM_SEL_LO = 21;
    localparam int CED_NUM_COP = 4;

    // primary opcode positions (row, column)
    localparam logic [2:0] CED_SPC1_ROW = 3'h0;
    localparam logic [2:0] CED_SPC1_COL = 3'h0;
    localparam logic [2:0] CED_SPC2_ROW = 3'h3;
    localparam logic [2:0] CED_SPC2_COL = 3'h4;

    // function positions in the first special class
    localparam logic [5:0] CED_FN_SHR_IMM = 6'h02;
    localparam logic [5:0] CED_FN_SHR_VAR = 6'h06;
    localparam logic [5:0] CED_FN_MV_FROM_LO = 6'h12;
    localparam logic [5:0] CED_FN_MV_TO_LO = 6'h13;
    localparam logic [5:0] CED_FN_UMUL = 6'h19;
    // function positions in the second special class
    localparam logic [5:0] CED_FN_UMAC = 6'h01;
    localparam logic [5:0] CED_FN_SCALED_LOAD = 6'h08;

    // sub-field values in bits 10..6; the shift select value is for bits 25..21
    localparam logic [4:0] CED_SUB_PLAIN = 5'h00;
    localparam logic [4:0] CED_SUB_ACCUM = 5'h01;
    localparam logic [4:0] CED_SUB_LOAD_WORD = 5'h02;
    localparam logic [4:0] CED_SUB_POLY = 5'h11;
    localparam logic [4:0] CED_SUB_PERM = 5'h12;
    localparam logic [4:0] CED_SUB_SHIFT_SEL = 5'h00;

    // reset values of the output stage
    localparam logic [31:0] CED_INSTR_RST = 32'h0000_0000;

    // decoded operation
    typedef enum logic [4:0] {
        CED_OP_BASE,
        CED_OP_LOGICAL_RIGHT_SHIFT_IMM,
        CED_OP_LOGICAL_RIGHT_SHIFT_VAR,
        CED_OP_ROTATE_RIGHT_VAR,
        CED_OP_MOVE_FROM_LOW_REG,
        CED_OP_ACCUM_SHIFT_OUT_MOVE,
        CED_OP_MOVE_TO_LOW_REG,
        CED_OP_ACCUM_SHIFT_IN_MOVE,
        CED_OP_UNSIGNED_MULTIPLY,
        CED_OP_POLYNOMIAL_MULTIPLY,
        CED_OP_UNSIGNED_MULTIPLY_ACCUMULATE,
        CED_OP_POLYNOMIAL_MULTIPLY_ACCUMULATE,
        CED_OP_PARTIAL_BIT_PERMUTE,
        CED_OP_SCALED_INDEXED_LOAD_WORD
    } ced_op_t;

    // field class that needs a second decode step
    typedef enum logic [2:0] {
        CED_CLS_NONE,
        CED_CLS_SHR_IMM,
        CED_CLS_SHR_VAR,
        CED_CLS_MV_FROM_LO,
        CED_CLS_MV_TO_LO,
        CED_CLS_UMUL,
        CED_CLS_UMAC,
        CED_CLS_SCALED_LOAD
    } ced_cls_t;

    // marking of an encoding as given by the base table
    typedef enum logic [2:0] {
        CED_MARK_NONE,
        CED_MARK_RESERVED,
        CED_MARK_HIGHER_LEVEL,
        CED_MARK_PARTNER,
        CED_MARK_DEBUG,
        CED_MARK_EXT_RESERVED,
        CED_MARK_OBSOLETE
    } ced_mark_t;

    // exception selected for the instruction
    typedef enum logic [1:0] {
        CED_EXC_NONE,
        CED_EXC_RESERVED_INSTR,
        CED_EXC_COP_UNUSABLE
    } ced_exc_t;

    // classification of the base table for one word
    typedef struct packed {
        ced_mark_t mark;
        logic is_cop;
        logic [1:0] cop_num;
    } ced_base_info_t;

    // decode result handed downstream
    typedef struct packed {
        ced_op_t op;
        ced_exc_t exc;
        logic [1:0] cop_num;
        logic ext_op;
        logic second_step;
        logic obsolete;
    } ced_dec_t;

endpackage : ced_pkg

// *** hdl/ced_subfield.sv ***
// second-step decode of the extension field classes
module ced_subfield
    import ced_pkg::*;
(
    // class and word
    input wire ced_cls_t cls_i,
    input wire logic [31:0] instr_i,
    // result
    output ced_op_t op_o,
    output logic base_form_o,
    output logic legal_o
);

    logic [4:0] sub;
    assign sub = instr_i[CED_SUB_HI:CED_SUB_LO];

    // sub-field tables
    always_comb begin
        op_o = CED_OP_BASE;
        base_form_o = 1'b1;
        legal_o = 1'b1;
        unique case (cls_i)
            CED_CLS_NONE: begin
            end
            CED_CLS_SHR_IMM: begin
                op_o = CED_OP_LOGICAL_RIGHT_SHIFT_IMM;
                legal_o = (instr_i[CED_IMM_SEL_HI:CED_IMM_SEL_LO] == CED_SUB_SHIFT_SEL);
            end
            CED_CLS_SHR_VAR: begin
                // bit 6 picks shift or rotate
                if (instr_i[CED_ROT_BIT]) begin
                    op_o = CED_OP_ROTATE_RIGHT_VAR;
                    base_form_o = 1'b0;
                end else begin
                    op_o = CED_OP_LOGICAL_RIGHT_SHIFT_VAR;
                end
            end
            CED_CLS_MV_FROM_LO: begin
                op_o = CED_OP_MOVE_FROM_LOW_REG;
                if (sub == CED_SUB_ACCUM) begin
                    op_o = CED_OP_ACCUM_SHIFT_OUT_MOVE;
                    base_form_o = 1'b0;
                end else begin
                    legal_o = (sub == CED_SUB_PLAIN);
                end
            end
            CED_CLS_MV_TO_LO: begin
                op_o = CED_OP_MOVE_TO_LOW_REG;
                if (sub == CED_SUB_ACCUM) begin
                    op_o = CED_OP_ACCUM_SHIFT_IN_MOVE;
                    base_form_o = 1'b0;
                end else begin
                    legal_o = (sub == CED_SUB_PLAIN);
                end
            end
            CED_CLS_UMUL: begin
                op_o = CED_OP_UNSIGNED_MULTIPLY;
                if (sub == CED_SUB_POLY) begin
                    op_o = CED_OP_POLYNOMIAL_MULTIPLY;
                    base_form_o = 1'b0;
                end else begin
                    legal_o = (sub == CED_SUB_PLAIN);
                end
            end
            CED_CLS_UMAC: begin
                op_o = CED_OP_UNSIGNED_MULTIPLY_ACCUMULATE;
                if (sub == CED_SUB_POLY) begin
                    op_o = CED_OP_POLYNOMIAL_MULTIPLY_ACCUMULATE;
                    base_form_o = 1'b0;
                end else if (sub == CED_SUB_PERM) begin
                    op_o = CED_OP_PARTIAL_BIT_PERMUTE;
                    base_form_o = 1'b0;
                end else begin
                    legal_o = (sub == CED_SUB_PLAIN);
                end
            end
            CED_CLS_SCALED_LOAD: begin
                op_o = CED_OP_SCALED_INDEXED_LOAD_WORD;
                base_form_o = 1'b0;
                legal_o = (sub == CED_SUB_LOAD_WORD);
            end
        endcase
    end

endmodule : ced_subfield

// *** hdl/ced_decoder.sv ***
// extension opcode decoder: class select, second step, exception choice
//
// Notes on behaviour
// - codes reserved for future use raise a reserved-instruction exception
// - a field class is never final; a further field picks the operation
// - encodings of a higher instruction set level raise reserved-instruction
// - unassigned partner codes: reserved-instruction, or cop-unusable if access denied
// - optional debug codes: reserved-instruction when absent, exact match when present
// - extension-reserved codes raise reserved-instruction when extension is absent
// - opcode row bits 31..29, column 28..26; 000/000 and 011/100 are classes
// - first class: right shifts, low-register moves, unsigned multiply need more decode
// - second class: multiply-accumulate and scaled load need sub-field decode
// - variable right shift: bit 6 clear shifts, set rotates
// - multiply-accumulate sub-field: plain, polynomial, partial permute
// - move-from-low sub-field: plain move or accumulator shift-out move
// - unsigned multiply sub-field: plain or polynomial multiply
module ced_decoder
    import ced_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // instruction from fetch
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    // base table classification of the same word
    input wire ced_base_info_t base_info_i,
    // core configuration
    input wire logic ext_present_i,
    input wire logic dbg_present_i,
    input wire logic [CED_NUM_COP-1:0] cop_usable_i,
    // decode result to the pipeline and exception unit
    output logic dec_valid_o,
    output logic [31:0] dec_instr_o,
    output ced_dec_t dec_o,
    output logic exc_req_o
);

    // primary and function fields
    logic [2:0] op_row;
    logic [2:0] op_col;
    logic [5:0] func;
    logic in_spc1;
    logic in_spc2;

    assign op_row = instr_i[CED_ROW_HI:CED_ROW_LO];
    assign op_col = instr_i[CED_COL_HI:CED_COL_LO];
    assign func = instr_i[CED_FROW_HI:CED_FCOL_LO];

    // row/column select of the two special classes
    assign in_spc1 = (op_row == CED_SPC1_ROW) && (op_col == CED_SPC1_COL);
    assign in_spc2 = (op_row == CED_SPC2_ROW) && (op_col == CED_SPC2_COL);

    // field class chosen by the function field
    ced_cls_t cls;

    always_comb begin
        cls = CED_CLS_NONE;
        if (in_spc1) begin
            // first class positions
            unique case (func)
                CED_FN_SHR_IMM: cls = CED_CLS_SHR_IMM;
                CED_FN_SHR_VAR: cls = CED_CLS_SHR_VAR;
                CED_FN_MV_FROM_LO: cls = CED_CLS_MV_FROM_LO;
                CED_FN_MV_TO_LO: cls = CED_CLS_MV_TO_LO;
                CED_FN_UMUL: cls = CED_CLS_UMUL;
                default: cls = CED_CLS_NONE;
            endcase
        end else if (in_spc2) begin
            // second class positions
            unique case (func)
                CED_FN_UMAC: cls = CED_CLS_UMAC;
                CED_FN_SCALED_LOAD: cls = CED_CLS_SCALED_LOAD;
                default: cls = CED_CLS_NONE;
            endcase
        end
    end

    // second decode step on the sub-fields
    ced_op_t sub_op;
    logic sub_base_form;
    logic sub_legal;

    ced_subfield u_subfield (
        .cls_i(cls),
        .instr_i(instr_i),
        .op_o(sub_op),
        .base_form_o(sub_base_form),
        .legal_o(sub_legal)
    );

    // coprocessor access per unit
    logic [CED_NUM_COP-1:0] cop_sel;
    logic cop_allowed;

    genvar gi;
    generate
        for (gi = 0; gi < CED_NUM_COP; gi++) begin : g_cop
            assign cop_sel[gi] = (base_info_i.cop_num == 2'(gi)) && cop_usable_i[gi];
        end
    endgenerate

    assign cop_allowed = |cop_sel;

    // exception chosen from the base table marking
    ced_exc_t base_exc;

    always_comb begin
        base_exc = CED_EXC_NONE;
        unique case (base_info_i.mark)
            CED_MARK_NONE: base_exc = CED_EXC_NONE;
            CED_MARK_OBSOLETE: base_exc = CED_EXC_NONE; // decoded, only flagged
            CED_MARK_RESERVED: base_exc = CED_EXC_RESERVED_INSTR;
            CED_MARK_HIGHER_LEVEL: base_exc = CED_EXC_RESERVED_INSTR;
            CED_MARK_PARTNER: begin
                // unassigned partner code
                if (base_info_i.is_cop && !cop_allowed) begin
                    base_exc = CED_EXC_COP_UNUSABLE;
                end else begin
                    base_exc = CED_EXC_RESERVED_INSTR;
                end
            end
            CED_MARK_DEBUG: begin
                // optional debug code
                base_exc = dbg_present_i ? CED_EXC_NONE : CED_EXC_RESERVED_INSTR;
            end
            CED_MARK_EXT_RESERVED: begin
                // extension slot in the base table
                base_exc = ext_present_i ? CED_EXC_NONE : CED_EXC_RESERVED_INSTR;
            end
            default: base_exc = CED_EXC_RESERVED_INSTR;
        endcase
    end

    // combined result for this word
    ced_dec_t nxt_dec;

    always_comb begin
        nxt_dec.op = CED_OP_BASE;
        nxt_dec.exc = base_exc;
        nxt_dec.cop_num = base_info_i.cop_num;
        nxt_dec.ext_op = 1'b0;
        nxt_dec.second_step = 1'b0;
        nxt_dec.obsolete = (base_info_i.mark == CED_MARK_OBSOLETE);
        if (cls != CED_CLS_NONE) begin
            // a class never ends decode; the sub-field result stands
            nxt_dec.second_step = 1'b1;
            nxt_dec.op = sub_op;
            nxt_dec.ext_op = !sub_base_form;
            nxt_dec.obsolete = 1'b0;
            if (!sub_legal) begin
                nxt_dec.exc = CED_EXC_RESERVED_INSTR;
            end else if (!sub_base_form && !ext_present_i) begin
                nxt_dec.exc = CED_EXC_RESERVED_INSTR;
            end else if (sub_base_form) begin
                nxt_dec.exc = base_exc; // plain forms keep base handling
            end else begin
                nxt_dec.exc = CED_EXC_NONE;
            end
        end
    end

    // valid stage
    logic dec_valid_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_valid_ff <= 1'b0;
        end else if (ce_i) begin
            dec_valid_ff <= instr_valid_i;
        end
    end

    // instruction word carried alongside the decode
    logic [31:0] dec_instr_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_instr_ff <= CED_INSTR_RST;
        end else if (ce_i && instr_valid_i) begin
            dec_instr_ff <= instr_i;
        end
    end

    // decode result register
    ced_dec_t dec_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_ff.op <= CED_OP_BASE;
            dec_ff.exc <= CED_EXC_NONE;
            dec_ff.cop_num <= 2'h0;
            dec_ff.ext_op <= 1'b0;
            dec_ff.second_step <= 1'b0;
            dec_ff.obsolete <= 1'b0;
        end else if (ce_i && instr_valid_i) begin
            dec_ff <= nxt_dec;
        end
    end

    // outputs
    assign dec_valid_o = dec_valid_ff;
    assign dec_instr_o = dec_instr_ff;
    assign dec_o = dec_ff;
    assign exc_req_o = dec_valid_ff && (dec_ff.exc != CED_EXC_NONE); // handshake term

endmodule : ced_decoder

// *** bench/ced_decoder_properties.sv ***
// concurrent checks on the ports of the extension opcode decoder
module ced_decoder_properties
    import ced_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // word and configuration
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire ced_base_info_t base_info_i,
    input wire logic ext_present_i,
    input wire logic dbg_present_i,
    input wire logic [CED_NUM_COP-1:0] cop_usable_i,
    // decode result
    input wire logic dec_valid_o,
    input wire logic [31:0] dec_instr_o,
    input wire ced_dec_t dec_o,
    input wire logic exc_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] fn;
    logic cls1;
    logic cls2;
    ced_mark_t mk;

    // class words by primary and function position
    assign fn = instr_i[5:0];
    assign mk = base_info_i.mark;
    assign cls1 = instr_i[31:26] == {CED_SPC1_ROW, CED_SPC1_COL} && (fn == CED_FN_SHR_IMM
        || fn == CED_FN_SHR_VAR || fn == CED_FN_MV_FROM_LO || fn == CED_FN_MV_TO_LO
        || fn == CED_FN_UMUL);
    assign cls2 = instr_i[31:26] == {CED_SPC2_ROW, CED_SPC2_COL}
        && (fn == CED_FN_UMAC || fn == CED_FN_SCALED_LOAD);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // accepted word, plain word, word with the extension present
    sequence take_s;
        ce_i && instr_valid_i;
    endsequence
    sequence plain_s;
        take_s ##0 !(cls1 || cls2);
    endsequence
    sequence ext_s;
        take_s ##0 ext_present_i;
    endsequence

    valid_latency_a: assert property (ce_i |=> dec_valid_o == $past(instr_valid_i))
        else $error("result valid not one cycle after word");
    instr_copy_a: assert property (take_s |=> dec_instr_o == $past(instr_i))
        else $error("word copy wrong");
    exc_req_a: assert property (exc_req_o == (dec_valid_o && dec_o.exc != CED_EXC_NONE))
        else $error("exception request disagrees with result");
    reserved_mark_a: assert property (plain_s ##0 mk == CED_MARK_RESERVED
        |=> dec_o.exc == CED_EXC_RESERVED_INSTR) else $error("reserved code not refused");
    higher_level_a: assert property (plain_s ##0 mk == CED_MARK_HIGHER_LEVEL
        |=> dec_o.exc == CED_EXC_RESERVED_INSTR) else $error("higher level code not refused");
    partner_code_a: assert property (plain_s ##0 mk == CED_MARK_PARTNER |=> dec_o.exc ==
        ($past(base_info_i.is_cop && !cop_usable_i[base_info_i.cop_num])
        ? CED_EXC_COP_UNUSABLE : CED_EXC_RESERVED_INSTR)) else $error("partner code wrong");
    debug_code_a: assert property (plain_s ##0 mk == CED_MARK_DEBUG |=> dec_o.exc ==
        ($past(dbg_present_i) ? CED_EXC_NONE : CED_EXC_RESERVED_INSTR))
        else $error("debug code exception wrong");
    ext_reserved_a: assert property (plain_s ##0 mk == CED_MARK_EXT_RESERVED
        |=> dec_o.exc == ($past(ext_present_i) ? CED_EXC_NONE : CED_EXC_RESERVED_INSTR))
        else $error("extension code exception wrong");
    class_step_a: assert property (take_s ##0 (cls1 || cls2)
        |=> dec_o.second_step && !dec_o.obsolete) else $error("class word taken as final");
    base_pass_a: assert property (plain_s ##0 mk == CED_MARK_NONE
        |=> dec_o.op == CED_OP_BASE && dec_o.exc == CED_EXC_NONE && !dec_o.second_step)
        else $error("base word altered");
    rotate_sel_a: assert property (ext_s ##0 (cls1 && fn == CED_FN_SHR_VAR)
        ##0 instr_i[6] |=> dec_o.op == CED_OP_ROTATE_RIGHT_VAR && dec_o.exc == CED_EXC_NONE)
        else $error("rotate not selected");
    umac_perm_a: assert property (ext_s ##0 (cls2 && fn == CED_FN_UMAC) ##0
        instr_i[10:6] == CED_SUB_PERM |=> dec_o.op == CED_OP_PARTIAL_BIT_PERMUTE)
        else $error("permute not selected");
endmodule : ced_decoder_properties

bind ced_decoder ced_decoder_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .base_info_i(base_info_i),
    .ext_present_i(ext_present_i), .dbg_present_i(dbg_present_i), .cop_usable_i(cop_usable_i),
    .dec_valid_o(dec_valid_o), .dec_instr_o(dec_instr_o), .dec_o(dec_o), .exc_req_o(exc_req_o));

// *** bench/ced_fetch_model.sv ***
// fetch stage model: presents words, scrambles the bus when idle
module ced_fetch_model
    import ced_pkg::*;
(
    // clock and request from the bench
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [31:0] word_i,
    input wire ced_base_info_t info_i,
    // word towards the decoder
    output logic instr_valid_o,
    output logic [31:0] instr_o,
    output ced_base_info_t base_info_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last_ff = '1;

    // remember the last word so idle cycles show its inverse
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            last_ff <= word_i;
        end
    end

    // idle bus never repeats the last word
    assign instr_valid_o = go_i;
    assign instr_o = go_i ? word_i : ~last_ff;
    assign base_info_o = go_i ? info_i : ~info_i;
endmodule : ced_fetch_model

// *** bench/tb_ced_decoder.sv ***
// self-checking bench for the extension opcode decoder
module tb_ced_decoder
    import ced_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam ced_exc_t NO = CED_EXC_NONE;
    localparam ced_exc_t RI = CED_EXC_RESERVED_INSTR;
    localparam ced_exc_t CU = CED_EXC_COP_UNUSABLE;
    localparam logic [31:0] tbl [22] = '{32'h00000002, 32'h00200042, 32'h00000006,
        32'h00000046, 32'h00000012, 32'h00000052, 32'h00000092, 32'h00000013, 32'h00000053,
        32'h00000093, 32'h00000019, 32'h00000459, 32'h00000059, 32'h70000001, 32'h70000441,
        32'h70000481, 32'h70000081, 32'h70000088, 32'h70000008, 32'h00000003, 32'h70000002,
        32'h8c000000};
    localparam logic [5:0] fns [8] = '{6'h02, 6'h06, 6'h12, 6'h13, 6'h19, 6'h01, 6'h08, 6'h03};
    logic clk_i = 0, rst_i = 1, ce_i = 1, go = 0, ext = 0, dbg = 0, run = 0;
    logic iv, dv, xr, ev = 0;
    logic [3:0] cop = '0;
    logic [31:0] word = '0, ins, di, ei = '0;
    logic [31:0] seed = 32'h0000a0bd; // 41149
    ced_base_info_t info = '0, bi;
    ced_dec_t dec, d, ed = '0;
    int fails = 0, samples_checked = 0;

    ced_fetch_model i_fetch (.clk_i(clk_i), .go_i(go), .word_i(word), .info_i(info),
        .instr_valid_o(iv), .instr_o(ins), .base_info_o(bi));
    ced_decoder i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_valid_i(iv),
        .instr_i(ins), .base_info_i(bi), .ext_present_i(ext), .dbg_present_i(dbg),
        .cop_usable_i(cop), .dec_valid_o(dv), .dec_instr_o(di), .dec_o(dec), .exc_req_o(xr));

    // 20 MHz clock
    initial forever #25 clk_i = ~clk_i;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic ced_base_info_t rinfo();
        logic [31:0] r;
        r = xs();
        return {3'(r[7:0] % 7), r[8], r[10:9]};
    endfunction : rinfo

    // expected decode of one word; ok low marks an illegal sub-field
    function automatic ced_dec_t ref_dec(logic [31:0] w, ced_base_info_t b);
        ced_dec_t r;
        ced_exc_t me;
        ced_op_t b0;
        int s, xv;
        logic [11:0] key;
        logic xf, ok;
        s = int'(w[10:6]);
        key = {w[31:26], w[5:0]};
        xv = 1;
        case (b.mark)
            CED_MARK_RESERVED, CED_MARK_HIGHER_LEVEL: me = RI;
            CED_MARK_PARTNER: me = (b.is_cop && !cop[b.cop_num]) ? CU : RI;
            CED_MARK_DEBUG: me = dbg ? NO : RI;
            CED_MARK_EXT_RESERVED: me = ext ? NO : RI;
            default: me = NO;
        endcase
        r = '0;
        r.exc = me;
        r.cop_num = b.cop_num;
        r.obsolete = b.mark == CED_MARK_OBSOLETE;
        r.second_step = 1;
        case (key)
            12'h002: b0 = CED_OP_LOGICAL_RIGHT_SHIFT_IMM;
            12'h006: b0 = CED_OP_LOGICAL_RIGHT_SHIFT_VAR;
            12'h012: b0 = CED_OP_MOVE_FROM_LOW_REG;
            12'h013: b0 = CED_OP_MOVE_TO_LOW_REG;
            12'h019: {b0, xv} = {CED_OP_UNSIGNED_MULTIPLY, 32'h11};
            12'h701: {b0, xv} = {CED_OP_UNSIGNED_MULTIPLY_ACCUMULATE, 32'h11};
            12'h708: {b0, xv} = {CED_OP_SCALED_INDEXED_LOAD_WORD, 32'h2};
            default: r.second_step = 0;
        endcase
        xf = s == xv || (key == 12'h701 && s == 18);
        ok = s == 0 || xf;
        if (key == 12'h006) {xf, ok} = {w[6], 1'b1};
        if (key == 12'h002) {xf, ok} = {1'b0, w[25:21] == 5'h00};
        if (key == 12'h708) ok = xf;
        if (r.second_step) begin
            r.obsolete = 0;
            r.ext_op = xf || key == 12'h708; // scaled load counts as extension even when illegal
            r.exc = (!ok || (xf && !ext)) ? RI : (xf ? NO : me);
            r.op = ced_op_t'(key == 12'h708 ? b0 : b0 + (xf ? 1 + (s == 18) : 0));
        end
        return r;
    endfunction : ref_dec

    // reference stage, updated on the same edge as the design
    always @(posedge clk_i) begin
        if (rst_i) begin
            {ev, ei, ed} <= {1'b0, 32'h0, 12'h0};
        end else if (ce_i) begin
            ev <= iv;
            if (iv) begin
                d = ref_dec(ins, bi);
                {ed, ei} <= {d, ins};
            end
        end
    end

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // compare the settled outputs mid-cycle
    always @(negedge clk_i) begin
        if (run) begin
            check(dv, ev);
            check(di, ei);
            check(xr, ev && ed.exc != NO);
            check(dec.exc, ed.exc);
            check(dec.second_step, ed.second_step);
            check(dec.obsolete, ed.obsolete);
            check(dec.cop_num, ed.cop_num);
            check(dec.op, ed.op);
            check(dec.ext_op, ed.ext_op);
        end
    end

    task automatic step(logic v, logic [31:0] w, ced_base_info_t b);
        {go, word, info} = {v, w, b};
        @(posedge clk_i);
        #1;
    endtask : step

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // main sequence: table under all four debug/extension settings (cop fixed), mark sweep, random run
    initial begin
        int unsigned i, c;
        logic [31:0] r, w;
        @(posedge clk_i);
        #1;
        run = 1;
        repeat (7) @(posedge clk_i);
        #1;
        rst_i = 0;
        for (c = 0; c < 4; c++) begin
            {dbg, ext, cop} = {c[1:0], 4'h5};
            foreach (tbl[k]) step(1, tbl[k], rinfo());
            // every mark, obsolete included, is swept here on one word, to see them flagged
            for (i = 0; i < 14; i++) step(1, tbl[21], {3'(i / 2), i[0], i[2:1]});
            step(0, '0, '0);
        end
        for (i = 0; i < 400; i++) begin
            r = xs();
            w = xs();
            {ce_i, dbg, ext, cop, rst_i} = {r[3:0] != 4'h0, r[5:4], r[9:6], i == 200};
            if (r[10]) w[31:26] = r[11] ? 6'h1c : 6'h00;
            if (r[12]) w[5:0] = fns[r[15:13]];
            step(r[16] | r[17], w, rinfo());
        end
        {rst_i, ce_i} = 2'b01;
        step(0, '0, '0);
        step(0, '0, '0);
        give_verdict();
    end

    // watchdog against a hang
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule : tb_ced_decoder
